/* File: hdl/gddr_wr_pkg.sv */
// Constants, types and encodings for the write, precharge and power-down block.
// Assumes a 200 MHz core clock that oversamples the DRAM command clock.
//
// How it works
// R01: WRITE carries column and bank; address bit 8 selects auto-precharge.
// R02: Auto-precharge closes the row after the burst, once row-active minimum passed.
// R03: First element on first strobe rise after write latency, then every strobe edge.
// R04: Controller drives a preamble: half cycle high, half cycle low.
// R05: Controller actively drives the strobe high for one postamble cycle.
// R06: Controller toggles the strobe only while data is transferred.
// R07: Controller places first strobe rise within latency plus or minus quarter clock.
// R08: After a burst, data lines stay undriven and extra data is ignored.
// R09: A write burst is never cut short by a later command.
// R10: Controller spaces writes at least half the burst length apart.
// R11: Controller waits write-to-read time, two clocks, before a READ.
// R12: Controller waits write recovery time before a PRECHARGE.
// R13: Controller waits precharge time before next command to that bank.
// R14: PRECHARGE closes one bank or all, chosen by address bit 8.
// R15: A precharged bank is idle and needs activation before READ or WRITE.
// R16: Controller holds clock enable high until the burst has completed.
// R17: Clock enable registered low enters power-down, active or precharge kind.
// R18: In power-down only clock and clock enable inputs are heard.
// R19: Controller waits 200 cycles before READ after loop re-enable.
// R20: Controller keeps clock enable low and clock stable during power-down.
// R21: Clock enable high with NOP or DESELECT exits power-down.
// R22: Controller prefers self-refresh for long idle periods.
// R23: WRITE code: select low, row high, column low, write enable low.
// R24: PRECHARGE code: select low, row low, column high, write enable low.
// R25: NOP is select low, rest high; select high is DESELECT.
// R26: Controller keeps its own per-bank timers and power-down exit counter; the model keeps neither, and the bench waits fixed times instead.

package gddr_wr_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RAS_MIN_NS = 40;
  localparam int RAS_MIN_CYC = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RAS_MIN_CNT = 8'(RAS_MIN_CYC);
  localparam int NUM_BANKS = 4;
  localparam int ADDR_W = 12;
  localparam int DQ_W = 32;
  localparam int BURST_LENGTH = 4;
  localparam logic [1:0] LAST_BEAT = 2'(BURST_LENGTH - 1);
  localparam int LAT_DEPTH = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int AP_BIT = 8;

  // ****************************************************************
  // Command codes {select, row, column, write enable}, active low
  // ****************************************************************
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic dclk;
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic strobe;
    logic [DQ_W-1:0] dq;
  } pins_type;

  typedef struct packed {
    logic valid;
    logic autoPre;
    logic [1:0] bank;
    logic [ADDR_W-1:0] addr;
  } wrcmd_type;

  typedef struct packed {
    logic [1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [1:0] beat;
    logic [DQ_W-1:0] data;
  } wrbeat_type;

  typedef enum logic [1:0] {PWR_ON = 2'h1, PWR_DOWN = 2'h2} pwr_type;
  typedef enum logic [1:0] {CAP_IDLE = 2'h1, CAP_RUN = 2'h2} cap_type;

endpackage : gddr_wr_pkg

/* File: hdl/dram_write_precharge_powerdown.sv */
// Write capture, precharge and power-down logic of the DRAM, plus its beat FIFO.
// Assumes all pins come from outside the clock domain and the command clock
// is far slower than clk, so every pin edge is seen after synchronisation.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Beat FIFO
// ****************************************************************
// Depth must be a power of two; pointers wrap by overflow.
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = count_q != (AW+1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData = mem_q[rdPtr_q];

  always_comb begin
    push = inValid & inReady;
    pop = outValid & outReady;
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule : sync_fifo

// ****************************************************************
// Top
// ****************************************************************
module dram_write_precharge_powerdown (
  input wire logic clk,
  input wire logic rst,
  input wire logic dclkPin,
  input wire logic ckePin,
  input wire logic csNPin,
  input wire logic rasNPin,
  input wire logic casNPin,
  input wire logic weNPin,
  input wire logic [1:0] bankPin,
  input wire logic [11:0] addrPin,
  input wire logic strobePin,
  input wire logic [31:0] dqIn,
  output logic [31:0] dqOut,
  output logic [31:0] dqOeN,
  input wire logic [1:0] writeLatency,
  output logic beatValid,
  input wire logic beatReady,
  output gddr_wr_pkg::wrbeat_type beatData,
  output logic [3:0] bankOpen,
  output logic powerDown,
  output logic activePowerDown,
  output logic burstBusy,
  output logic overflow
);
  gddr_wr_pkg::pins_type s1_q, s2_q, pinsRaw;
  logic dclkD_q, strobeD_q;
  logic dRise, dFall, sRise, sFall;
  logic [3:0] cmdCode;
  logic isNop, cmdLive, wrHit, preHit, actHit;
  wire logic [3:0] openV;
  gddr_wr_pkg::pwr_type pwr_q, pwr_d;
  logic actPd_q, actPd_d;
  gddr_wr_pkg::wrcmd_type lat_q [gddr_wr_pkg::LAT_DEPTH];
  gddr_wr_pkg::wrcmd_type lat_d [gddr_wr_pkg::LAT_DEPTH];
  gddr_wr_pkg::wrcmd_type newCmd, sel, pend_q, pend_d, cur_q, cur_d;
  gddr_wr_pkg::cap_type cap_q, cap_d;
  logic [1:0] beat_q, beat_d, latIdx;
  logic armed, wEdge, load, push, done, fifoReady;
  logic busy_q, busy_d, ovf_q, ovf_d;
  gddr_wr_pkg::wrbeat_type pushData;

  // ****************************************************************
  // Pin synchronisers and edge finding
  // ****************************************************************
  assign pinsRaw = '{dclk: dclkPin, cke: ckePin, csN: csNPin, rasN: rasNPin,
                     casN: casNPin, weN: weNPin, bank: bankPin, addr: addrPin,
                     strobe: strobePin, dq: dqIn};

  always_ff @(posedge clk) begin
    s1_q <= pinsRaw;
    s2_q <= s1_q;
    dclkD_q <= s2_q.dclk;
    strobeD_q <= s2_q.strobe;
  end

  assign dRise = s2_q.dclk & ~dclkD_q;
  assign dFall = ~s2_q.dclk & dclkD_q;
  assign sRise = s2_q.strobe & ~strobeD_q;
  assign sFall = ~s2_q.strobe & strobeD_q;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign cmdCode = {s2_q.csN, s2_q.rasN, s2_q.casN, s2_q.weN};
  assign isNop = s2_q.csN | (cmdCode == gddr_wr_pkg::CMD_NOP); // see R25
  // Commands count only while powered up and clock enable high
  assign cmdLive = dRise & (pwr_q == gddr_wr_pkg::PWR_ON) & s2_q.cke; // see R18
  // Writes to an idle bank are dropped
  assign wrHit = cmdLive & (cmdCode == gddr_wr_pkg::CMD_WRITE)
               & openV[s2_q.bank]; // see R23 see R15
  assign preHit = cmdLive & (cmdCode == gddr_wr_pkg::CMD_PRECHARGE); // see R24
  assign actHit = cmdLive & (cmdCode == gddr_wr_pkg::CMD_ACTIVE);

  // ****************************************************************
  // Power-down
  // ****************************************************************
  always_comb begin
    pwr_d = pwr_q;
    actPd_d = actPd_q;
    if (dRise) begin
      case (pwr_q)
        gddr_wr_pkg::PWR_ON: if (!s2_q.cke) begin
          pwr_d = gddr_wr_pkg::PWR_DOWN; // see R17
          actPd_d = |openV;
        end
        gddr_wr_pkg::PWR_DOWN: if (s2_q.cke && isNop) begin
          pwr_d = gddr_wr_pkg::PWR_ON; // see R21
          actPd_d = 1'b0;
        end
        default: pwr_d = gddr_wr_pkg::PWR_ON;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_q <= gddr_wr_pkg::PWR_ON;
      actPd_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      actPd_q <= actPd_d;
    end
  end

  // ****************************************************************
  // Write latency pipe and strobe capture
  // ****************************************************************
  assign newCmd = '{valid: wrHit, autoPre: s2_q.addr[gddr_wr_pkg::AP_BIT],
                    bank: s2_q.bank, addr: s2_q.addr}; // see R01
  assign latIdx = (writeLatency == 2'h0) ? 2'h0 : writeLatency - 2'h1;
  assign sel = lat_q[latIdx];
  assign pushData = '{bank: cur_q.bank, addr: cur_q.addr, beat: beat_q,
                      data: s2_q.dq};

  always_comb begin
    for (int i = 0; i < gddr_wr_pkg::LAT_DEPTH; i++) begin
      lat_d[i] = lat_q[i];
    end
    if (dRise) begin
      lat_d[0] = newCmd;
      for (int i = 1; i < gddr_wr_pkg::LAT_DEPTH; i++) begin
        lat_d[i] = lat_q[i-1];
      end
    end
    cap_d = cap_q;
    cur_d = cur_q;
    beat_d = beat_q;
    pend_d = pend_q;
    push = 1'b0;
    done = 1'b0;
    load = 1'b0;
    // Arm half a clock early so a strobe a quarter clock early is still caught
    armed = dFall & sel.valid & (pwr_q == gddr_wr_pkg::PWR_ON); // see R07
    // First beat only on a rise, so the preamble fall is skipped
    wEdge = ((beat_q == 2'h0) ? sRise : (sRise | sFall))
          & (pwr_q == gddr_wr_pkg::PWR_ON); // see R03 see R04
    case (cap_q)
      gddr_wr_pkg::CAP_IDLE: if (pend_q.valid) begin
        load = 1'b1;
      end
      gddr_wr_pkg::CAP_RUN: if (wEdge) begin
        push = 1'b1;
        beat_d = beat_q + 2'h1;
        if (beat_q == gddr_wr_pkg::LAST_BEAT) begin
          done = 1'b1;
          if (pend_q.valid) begin
            load = 1'b1;
          end else begin
            cap_d = gddr_wr_pkg::CAP_IDLE; // see R08
          end
        end
      end
      default: cap_d = gddr_wr_pkg::CAP_IDLE;
    endcase
    // Commands never abort a running burst
    if (load) begin
      cur_d = pend_q; // see R09
      cap_d = gddr_wr_pkg::CAP_RUN;
      beat_d = 2'h0;
      pend_d.valid = 1'b0;
    end
    if (armed) begin
      pend_d = sel;
    end
    busy_d = (cap_d == gddr_wr_pkg::CAP_RUN) | pend_d.valid;
    for (int i = 0; i < gddr_wr_pkg::LAT_DEPTH; i++) begin
      busy_d = busy_d | lat_d[i].valid;
    end
    // Full FIFO loses the beat; the sticky flag tells the user
    ovf_d = ovf_q | (push & ~fifoReady);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < gddr_wr_pkg::LAT_DEPTH; i++) begin
        lat_q[i] <= '0;
      end
      cap_q <= gddr_wr_pkg::CAP_IDLE;
      cur_q <= '0;
      beat_q <= 2'h0;
      pend_q <= '0;
      busy_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      lat_q <= lat_d;
      cap_q <= cap_d;
      cur_q <= cur_d;
      beat_q <= beat_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      ovf_q <= ovf_d;
    end
  end

  sync_fifo #(
    .WIDTH($bits(gddr_wr_pkg::wrbeat_type)),
    .DEPTH(gddr_wr_pkg::FIFO_DEPTH)
  ) beatFifo (
    .clk(clk),
    .rst(rst),
    .inValid(push),
    .inReady(fifoReady),
    .inData(pushData),
    .outValid(beatValid),
    .outReady(beatReady),
    .outData(beatData)
  );

  // ****************************************************************
  // Banks
  // ****************************************************************
  for (genvar b = 0; b < gddr_wr_pkg::NUM_BANKS; b++) begin : perBank
    logic open_q, open_d, apw_q, apw_d;
    logic [7:0] ras_q, ras_d;
    assign openV[b] = open_q;

    always_comb begin
      open_d = open_q;
      apw_d = apw_q;
      ras_d = (open_q && ras_q != gddr_wr_pkg::RAS_MIN_CNT) ? ras_q + 8'h1 : ras_q;
      if (done && cur_q.autoPre && cur_q.bank == 2'(b)) begin
        apw_d = 1'b1;
      end
      if (apw_q && ras_q == gddr_wr_pkg::RAS_MIN_CNT) begin
        open_d = 1'b0; // see R02
        apw_d = 1'b0;
      end
      if (preHit && (s2_q.addr[gddr_wr_pkg::AP_BIT] || s2_q.bank == 2'(b))) begin
        open_d = 1'b0; // see R14
        apw_d = 1'b0;
      end
      if (actHit && !open_q && s2_q.bank == 2'(b)) begin
        open_d = 1'b1;
        ras_d = 8'h0;
        apw_d = 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        open_q <= 1'b0;
        apw_q <= 1'b0;
        ras_q <= 8'h0;
      end else begin
        open_q <= open_d;
        apw_q <= apw_d;
        ras_q <= ras_d;
      end
    end

    AST_AP_WAITS: assert property (@(posedge clk) disable iff (rst) // see R02
      apw_q && ras_q != gddr_wr_pkg::RAS_MIN_CNT && !preHit |=> open_q)
      else $error("auto-precharge closed row before row-active minimum");
    AST_AP_CLOSES: assert property (@(posedge clk) disable iff (rst) // see R02
      apw_q && ras_q == gddr_wr_pkg::RAS_MIN_CNT && !actHit |=> !open_q)
      else $error("auto-precharge did not close the row");
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The data lines are never driven here; read data lives elsewhere
  assign dqOut = 32'h0000_0000; // see R08
  assign dqOeN = 32'hffff_ffff;
  assign bankOpen = openV;
  assign powerDown = pwr_q[1];
  assign activePowerDown = actPd_q;
  assign burstBusy = busy_q;
  assign overflow = ovf_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence pdEnter;
    pwr_q == gddr_wr_pkg::PWR_ON && dRise && !s2_q.cke;
  endsequence
  sequence pdLeave;
    pwr_q == gddr_wr_pkg::PWR_DOWN && dRise && s2_q.cke && isNop;
  endsequence

  AST_PD_ENTRY: assert property (@(posedge clk) disable iff (rst) // see R17
    pdEnter |=> pwr_q == gddr_wr_pkg::PWR_DOWN && actPd_q == $past(|openV))
    else $error("power-down entry or kind wrong");
  AST_PD_EXIT: assert property (@(posedge clk) disable iff (rst) // see R21
    pdLeave |=> pwr_q == gddr_wr_pkg::PWR_ON ##1 !activePowerDown)
    else $error("power-down exit missed");
  AST_PD_DEAF: assert property (@(posedge clk) disable iff (rst) // see R18
    pwr_q == gddr_wr_pkg::PWR_DOWN |-> !wrHit && !preHit && !push)
    else $error("input heard during power-down");
  AST_PRE_ALL: assert property (@(posedge clk) disable iff (rst) // see R14
    preHit && s2_q.addr[gddr_wr_pkg::AP_BIT] |=> openV == 4'h0)
    else $error("precharge all left a bank open");
  AST_PRE_ONE: assert property (@(posedge clk) disable iff (rst) // see R14
    preHit && !s2_q.addr[gddr_wr_pkg::AP_BIT] && !actHit
    |=> !openV[$past(s2_q.bank)])
    else $error("single-bank precharge missed its bank");
  AST_FIRST_RISE: assert property (@(posedge clk) disable iff (rst) // see R03
    push && beat_q == 2'h0 |-> sRise)
    else $error("first beat not on a strobe rise");
  AST_IDLE_IGNORES: assert property (@(posedge clk) disable iff (rst) // see R08
    cap_q == gddr_wr_pkg::CAP_IDLE |-> !push)
    else $error("data taken outside a burst");
  AST_NO_TRUNC: assert property (@(posedge clk) disable iff (rst) // see R09
    cap_q == gddr_wr_pkg::CAP_RUN && !wEdge
    |=> cap_q == gddr_wr_pkg::CAP_RUN && beat_q == $past(beat_q))
    else $error("burst moved without a strobe edge");
  AST_ARM: assert property (@(posedge clk) disable iff (rst) // see R07
    armed |=> pend_q.valid && pend_q.bank == $past(sel.bank))
    else $error("write latency did not arm capture");
  AST_AP_FLAG: assert property (@(posedge clk) disable iff (rst) // see R01
    wrHit |=> lat_q[0].valid && lat_q[0].autoPre == $past(s2_q.addr[gddr_wr_pkg::AP_BIT]))
    else $error("auto-precharge bit not kept with write");
endmodule : dram_write_precharge_powerdown

`default_nettype wire

/* File: sim/dram_ctrl_model.sv */
// Controller-side model: drives command, strobe and write data pins of the DRAM.
// Assumes the bench calls its tasks in a legal order; the command clock runs free.
`timescale 1ns/10ps
`default_nettype none

module dram_ctrl_model (
  output logic dclk,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [1:0] bank,
  output logic [11:0] addr,
  output logic strobe,
  output logic [31:0] dq
);
  int pending;

  // ****************************************************************
  // Clock and idle levels
  // ****************************************************************
  initial begin
    dclk = 1'h0;
    forever #40 dclk = ~dclk;
  end

  initial begin
    cke = 1'h1;
    {csN, rasN, casN, weN} = gddr_wr_pkg::CMD_NOP;
    bank = 2'h0;
    addr = 12'h000;
    strobe = 1'h1;
    dq = 32'h5a5a_0f0f;
    pending = 0;
  end

  // ****************************************************************
  // Command and burst tasks
  // ****************************************************************
  // Released address lines show the inverse, so stale values never pass
  task automatic cmd(input logic [3:0] code, input logic [1:0] b, input logic [11:0] a);
    @(negedge dclk);
    {csN, rasN, casN, weN} = code;
    bank = b;
    addr = a;
    @(negedge dclk);
    {csN, rasN, casN, weN} = gddr_wr_pkg::CMD_NOP;
    bank = ~b;
    addr = ~a;
  endtask : cmd

  task setCke(input logic v);
    @(negedge dclk);
    cke = v;
  endtask : setCke

  // First strobe rise lands exactly at the latency, inside the window
  // Automatic, so overlapping bursts keep their own arguments
  task automatic doWrite(input logic [1:0] b, input logic [11:0] a,
                         input logic [1:0] latency, input logic [31:0] d0);
    int e;
    @(negedge dclk);
    {csN, rasN, casN, weN} = gddr_wr_pkg::CMD_WRITE;
    bank = b;
    addr = a;
    @(posedge dclk);
    #40;
    {csN, rasN, casN, weN} = gddr_wr_pkg::CMD_NOP;
    bank = ~b;
    addr = ~a;
    #(int'(latency) * 80 - 80);
    // A burst still streaming leaves the strobe low, so no second preamble
    if (pending == 0) strobe = 1'h0;
    pending++;
    for (e = 0; e < 4; e++) begin
      #20 dq = d0 + 32'(e);
      #20 strobe = ~e[0];
    end
    // Back-to-back bursts share the lines, so only the last one lets go
    #20 if (pending == 1) dq = ~dq;
    #20 if (pending == 1) strobe = 1'h1;
    pending--;
  endtask : doWrite
endmodule : dram_ctrl_model

`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the write, precharge and power-down block.
// Assumes the controller model drives all pins; the bench pops beats and checks.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk;
  logic rst;
  logic dclkPin;
  logic ckePin;
  logic csNPin;
  logic rasNPin;
  logic casNPin;
  logic weNPin;
  logic [1:0] bankPin;
  logic [11:0] addrPin;
  logic strobePin;
  logic [31:0] dqIn;
  logic [31:0] dqOut;
  logic [31:0] dqOeN;
  logic [1:0] writeLatency;
  logic beatValid;
  logic beatReady;
  gddr_wr_pkg::wrbeat_type beatData;
  logic [3:0] bankOpen;
  logic powerDown;
  logic activePowerDown;
  logic burstBusy;
  logic overflow;
  int errors;
  int num_checks;
  int latency;

  dram_write_precharge_powerdown u_dram_write_precharge_powerdown (
    .clk(clk), .rst(rst), .dclkPin(dclkPin), .ckePin(ckePin), .csNPin(csNPin),
    .rasNPin(rasNPin), .casNPin(casNPin), .weNPin(weNPin), .bankPin(bankPin),
    .addrPin(addrPin), .strobePin(strobePin), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .writeLatency(writeLatency), .beatValid(beatValid), .beatReady(beatReady),
    .beatData(beatData), .bankOpen(bankOpen), .powerDown(powerDown),
    .activePowerDown(activePowerDown), .burstBusy(burstBusy), .overflow(overflow)
  );

  dram_ctrl_model u_dram_ctrl_model (
    .dclk(dclkPin), .cke(ckePin), .csN(csNPin), .rasN(rasNPin), .casN(casNPin),
    .weN(weNPin), .bank(bankPin), .addr(addrPin), .strobe(strobePin), .dq(dqIn)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Checks and helpers
  // ****************************************************************
  task results;
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task chkBit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chkBit

  task chkVec(input string name, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chkVec

  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task doReset(input logic [1:0] lat);
    @(posedge clk);
    #1;
    rst = 1'h1;
    writeLatency = lat;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    repeat (4) @(posedge dclkPin);
  endtask : doReset

  // Auto-precharge bit is left out of the address comparison
  task popBeat(input logic [1:0] b, input logic [11:0] a, input logic [1:0] n,
               input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    #1;
    while (beatValid !== 1'h1) begin
      i++;
      if (i > 200) begin
        errors++;
        $display("ERROR beatValid expected 1 seen %b", beatValid);
        results();
      end
      @(posedge clk);
      #1;
    end
    chkVec("beatData", {1'h0, b, a[11:9], a[7:0], n, d},
           {1'h0, beatData.bank, beatData.addr[11:9], beatData.addr[7:0],
            beatData.beat, beatData.data});
    beatReady = 1'h1;
    @(posedge clk);
    #1;
    beatReady = 1'h0;
  endtask : popBeat

  task popBurst(input logic [1:0] b, input logic [11:0] a, input logic [31:0] d);
    int n;
    for (n = 0; n < 4; n++) popBeat(b, a, 2'(n), d + 32'(n));
  endtask : popBurst

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    rst = 1'h1;
    writeLatency = 2'h3;
    beatReady = 1'h0;
    errors = 0;
    num_checks = 0;
    // Latency code 0 runs as latency 1
    for (latency = 0; latency <= 3; latency++) begin
      doReset(2'(latency));
      chkVec("bankOpen", 48'h0, {44'h0, bankOpen});
      chkBit("powerDown", 1'h0, powerDown);
      chkBit("overflow", 1'h0, overflow);
      chkVec("dqOeN", 48'h0000_ffff_ffff, {16'h0, dqOeN});
      chkVec("dqOut", 48'h0, {16'h0, dqOut});
      u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'(latency), 12'h000);
      settle();
      chkVec("bankOpen", 48'(4'h1 << latency), {44'h0, bankOpen});
      u_dram_ctrl_model.doWrite(2'(latency), 12'h020 + 12'(latency),
                                (latency == 0) ? 2'h1 : 2'(latency), 32'(latency) << 28);
      popBurst(2'(latency), 12'h020 + 12'(latency), 32'(latency) << 28);
      chkBit("burstBusy", 1'h0, burstBusy);
    end
    // Write to a closed bank and its strobe must leave no beats
    u_dram_ctrl_model.doWrite(2'h0, 12'h030, 2'h3, 32'hc000_0000);
    settle();
    chkBit("beatValid", 1'h0, beatValid);
    // Back-to-back writes at the minimum spacing
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'h0, 12'h000);
    fork
      u_dram_ctrl_model.doWrite(2'h0, 12'h040, 2'h3, 32'ha000_0000);
      begin
        repeat (2) @(negedge dclkPin);
        u_dram_ctrl_model.doWrite(2'h3, 12'h044, 2'h3, 32'hb000_0000);
      end
    join
    popBurst(2'h0, 12'h040, 32'ha000_0000);
    popBurst(2'h3, 12'h044, 32'hb000_0000);
    // Single-bank and all-bank precharge
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'h2, 12'h000);
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_PRECHARGE, 2'h2, 12'h000);
    settle();
    chkVec("bankOpen", 48'h9, {44'h0, bankOpen});
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'h1, 12'h000);
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_PRECHARGE, 2'h2, 12'h100);
    settle();
    chkVec("bankOpen", 48'h0, {44'h0, bankOpen});
    // Auto-precharge holds the row until the burst is done
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'h1, 12'h000);
    fork
      u_dram_ctrl_model.doWrite(2'h1, 12'h108, 2'h3, 32'hd000_0000);
      begin
        repeat (4) @(posedge dclkPin);
        repeat (8) @(posedge clk);
        #1;
        chkBit("bankOpen1", 1'h1, bankOpen[1]);
        chkBit("burstBusy", 1'h1, burstBusy);
      end
    join
    settle();
    chkVec("bankOpen", 48'h0, {44'h0, bankOpen});
    popBurst(2'h1, 12'h108, 32'hd000_0000);
    // Active power-down ignores commands and strobes
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'h2, 12'h000);
    u_dram_ctrl_model.setCke(1'h0);
    @(posedge dclkPin);
    settle();
    chkBit("powerDown", 1'h1, powerDown);
    chkBit("activePowerDown", 1'h1, activePowerDown);
    u_dram_ctrl_model.doWrite(2'h2, 12'h050, 2'h3, 32'he000_0000);
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_PRECHARGE, 2'h2, 12'h100);
    settle();
    chkBit("beatValid", 1'h0, beatValid);
    chkVec("bankOpen", 48'h4, {44'h0, bankOpen});
    // Power-down stays short and no READ ever follows a write or an exit
    u_dram_ctrl_model.setCke(1'h1);
    @(posedge dclkPin);
    settle();
    chkBit("powerDown", 1'h0, powerDown);
    repeat (4) @(posedge dclkPin);
    // Precharge power-down with all banks idle
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_PRECHARGE, 2'h0, 12'h100);
    u_dram_ctrl_model.setCke(1'h0);
    @(posedge dclkPin);
    settle();
    chkBit("powerDown", 1'h1, powerDown);
    chkBit("activePowerDown", 1'h0, activePowerDown);
    u_dram_ctrl_model.setCke(1'h1);
    repeat (5) @(posedge dclkPin);
    chkBit("powerDown", 1'h0, powerDown);
    // Overfill the beat buffer while the reader stalls
    u_dram_ctrl_model.cmd(gddr_wr_pkg::CMD_ACTIVE, 2'h0, 12'h000);
    u_dram_ctrl_model.doWrite(2'h0, 12'h060, 2'h3, 32'h1100_0000);
    u_dram_ctrl_model.doWrite(2'h0, 12'h064, 2'h3, 32'h2200_0000);
    u_dram_ctrl_model.doWrite(2'h0, 12'h068, 2'h3, 32'h3300_0000);
    settle();
    chkBit("overflow", 1'h1, overflow);
    popBurst(2'h0, 12'h060, 32'h1100_0000);
    popBurst(2'h0, 12'h064, 32'h2200_0000);
    chkBit("beatValid", 1'h0, beatValid);
    results();
  end
endmodule : tb_top

`default_nettype wire
